//--- design/flash_host_pkg.sv
// constants of the flash host controller: register map, command words, timing
// assumes a 100 MHz mclk and a byte-wide parallel flash with 19 address lines
package flash_host_pkg;
	// register byte offsets on the Avalon-MM slave
	localparam logic [3:0]  REG_CMD    = 4'h0;
	localparam logic [3:0]  REG_ADDR   = 4'h4;
	localparam logic [3:0]  REG_WDATA  = 4'h8;
	localparam logic [3:0]  REG_STATUS = 4'hc;
	// status field positions
	localparam int ST_BUSY    = 0;
	localparam int ST_WINOPEN = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_RDATA   = 8;
	// operation codes written to REG_CMD[3:0]
	localparam logic [3:0] OP_READ     = 4'h0;
	localparam logic [3:0] OP_RESET    = 4'h1;
	localparam logic [3:0] OP_AUTOSEL  = 4'h2;
	localparam logic [3:0] OP_PROGRAM  = 4'h3;
	localparam logic [3:0] OP_CHIPERA  = 4'h4;
	localparam logic [3:0] OP_SECTERA  = 4'h5;
	localparam logic [3:0] OP_SECTADD  = 4'h6;
	localparam logic [3:0] OP_SUSPEND  = 4'h7;
	localparam logic [3:0] OP_RESUME   = 4'h8;
	// bus cycle words
	localparam logic [18:0] UNLOCK1_ADDR = 19'h00555;
	localparam logic [18:0] UNLOCK2_ADDR = 19'h002aa;
	localparam logic [7:0]  UNLOCK1_DATA = 8'haa;
	localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
	localparam logic [7:0]  CMD_RESET    = 8'hf0;
	localparam logic [7:0]  CMD_AUTOSEL  = 8'h90;
	localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;
	localparam logic [7:0]  CMD_ERASE    = 8'h80;
	localparam logic [7:0]  CMD_CHIPERA  = 8'h10;
	localparam logic [7:0]  CMD_SECTERA  = 8'h30;
	localparam logic [7:0]  CMD_SUSPEND  = 8'hb0;
	localparam logic [7:0]  CMD_RESUME   = 8'h30;
	localparam int          SECT_LSB     = 16;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_WP_NS       = 40;
	localparam int T_ACC_NS      = 70;
	localparam int T_WIN_US      = 50;
	localparam int WP_CYC        = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC       = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
	localparam int WIN_CYC       = T_WIN_US * 1000 / CLK_PERIOD_NS;
	localparam int CMD_SYNC      = 2;
endpackage

//--- design/flash_host.sv
// host controller that drives a parallel NOR flash through its strobes
// assumes software on Avalon-MM (waitrequest) and the flash pins wired directly;
// dq is split into in/out/enable, the bench resolves the wire
`timescale 1ns/100ps
`default_nettype none
module flash_host #(
	parameter int WIN_CYCLES = flash_host_pkg::WIN_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        en,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [18:0] flash_addr,
	input  wire logic [7:0]  flash_dq_in,
	output logic      [7:0]  flash_dq_out,
	output logic             flash_dq_oe,
	output logic             chip_enable_n,
	output logic             write_enable_n,
	output logic             output_enable_n
);
	generate
		if (WIN_CYCLES < 2 || WIN_CYCLES > 65535) begin : g_bad
			$error("WIN_CYCLES out of range");
		end
	endgenerate

	typedef enum logic [5:0] {
		S_IDLE   = 6'h01,
		S_SETUP  = 6'h02,
		S_STROBE = 6'h04,
		S_HOLD   = 6'h08,
		S_RDWAIT = 6'h10,
		S_RDTAKE = 6'h20
	} state_t;

	state_t      state_q;
	logic [3:0]  op_q;
	logic [2:0]  step_q;
	logic [7:0]  cnt_q;
	logic [18:0] addr_q;
	logic [7:0]  wdata_q;
	logic [7:0]  rdata_q;
	logic [7:0]  dq_s1_q;
	logic [7:0]  dq_s2_q;
	logic [15:0] win_q;
	logic        win_act_q;
	logic        refused_q;
	logic        rd_ack_q;
	logic        cmd_wr;
	logic        win_open;
	logic        busy;

	// number of write cycles of each operation; zero means a read cycle
	function automatic logic [2:0] op_len(input logic [3:0] op);
		unique case (op)
			flash_host_pkg::OP_RESET,
			flash_host_pkg::OP_SUSPEND,
			flash_host_pkg::OP_RESUME,
			flash_host_pkg::OP_SECTADD: op_len = 3'h1;
			flash_host_pkg::OP_AUTOSEL: op_len = 3'h3;
			flash_host_pkg::OP_PROGRAM: op_len = 3'h4;
			flash_host_pkg::OP_CHIPERA,
			flash_host_pkg::OP_SECTERA: op_len = 3'h6;
			default:                    op_len = 3'h0;
		endcase
	endfunction

	// address and data of one bus write step
	function automatic logic [26:0] step_word(input logic [3:0] op, input logic [2:0] step,
			input logic [18:0] a, input logic [7:0] d);
		logic [18:0] sa;
		sa = {a[18:16], 16'h0000};
		step_word = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA};
		if (op == flash_host_pkg::OP_RESET)
			step_word = {19'h00000, flash_host_pkg::CMD_RESET};
		else if (op == flash_host_pkg::OP_SUSPEND)
			step_word = {19'h00000, flash_host_pkg::CMD_SUSPEND};
		else if (op == flash_host_pkg::OP_RESUME)
			step_word = {19'h00000, flash_host_pkg::CMD_RESUME};
		else if (op == flash_host_pkg::OP_SECTADD)
			step_word = {sa, flash_host_pkg::CMD_SECTERA};
		else if (step == 3'h1 || step == 3'h4)
			step_word = {flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::UNLOCK2_DATA};
		else if (step == 3'h2) begin
			unique case (op)
				flash_host_pkg::OP_AUTOSEL: step_word[7:0] = flash_host_pkg::CMD_AUTOSEL;
				flash_host_pkg::OP_PROGRAM: step_word[7:0] = flash_host_pkg::CMD_PROGRAM;
				default:                    step_word[7:0] = flash_host_pkg::CMD_ERASE;
			endcase
		end else if (step == 3'h3 && op == flash_host_pkg::OP_PROGRAM)
			step_word = {a, d};
		else if (step == 3'h5 && op == flash_host_pkg::OP_CHIPERA)
			step_word[7:0] = flash_host_pkg::CMD_CHIPERA;
		else if (step == 3'h5)
			step_word = {sa, flash_host_pkg::CMD_SECTERA};
	endfunction

	assign busy     = (state_q != S_IDLE);
	assign win_open = win_act_q && (win_q < WIN_CYCLES[15:0]);
	assign cmd_wr   = en && avs_write && !busy && (avs_address == flash_host_pkg::REG_CMD);
	// a command write stalls until the previous operation has finished
	assign avs_waitrequest = (avs_write && busy && avs_address == flash_host_pkg::REG_CMD)
		|| (avs_read && !rd_ack_q);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			addr_q  <= 19'h00000;
			wdata_q <= 8'h00;
		end else if (en && avs_write && avs_address == flash_host_pkg::REG_ADDR) begin
			addr_q <= avs_writedata[18:0];
		end else if (en && avs_write && avs_address == flash_host_pkg::REG_WDATA) begin
			wdata_q <= avs_writedata[7:0];
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_ack_q     <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else if (en) begin
			rd_ack_q <= avs_read && !rd_ack_q;
			unique case (avs_address)
				flash_host_pkg::REG_ADDR:   avs_readdata <= {13'h0000, addr_q};
				flash_host_pkg::REG_WDATA:  avs_readdata <= {24'h000000, wdata_q};
				flash_host_pkg::REG_STATUS: avs_readdata <= {16'h0000, rdata_q, 5'h00,
					refused_q, win_open, busy};
				default:                    avs_readdata <= 32'h00000000;
			endcase
		end
	end

	// pin inputs pass two flip-flops
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dq_s1_q <= 8'h00;
			dq_s2_q <= 8'h00;
		end else if (en) begin
			dq_s1_q <= flash_dq_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	// a sector addition outside the open window is refused, not sent
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			refused_q <= 1'b0;
		else if (en && cmd_wr)
			refused_q <= (avs_writedata[3:0] == flash_host_pkg::OP_SECTADD) && !win_open;
	end

	// window timer restarts at the rising write strobe of the last sector erase or addition step; the last step of any other write op stops it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			win_act_q <= 1'b0;
			win_q     <= 16'h0000;
		end else if (en) begin
			if (state_q == S_STROBE && cnt_q == 8'h00 && step_q == op_len(op_q) - 3'h1) begin
				win_act_q <= (op_q == flash_host_pkg::OP_SECTERA) || (op_q == flash_host_pkg::OP_SECTADD);
				win_q     <= 16'h0000;
			end else if (win_act_q && win_q != 16'hffff) begin
				win_q <= win_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q         <= S_IDLE;
			op_q            <= flash_host_pkg::OP_READ;
			step_q          <= 3'h0;
			cnt_q           <= 8'h00;
			rdata_q         <= 8'h00;
			flash_addr      <= 19'h00000;
			flash_dq_out    <= 8'h00;
			flash_dq_oe     <= 1'b0;
			chip_enable_n   <= 1'b1;
			write_enable_n  <= 1'b1;
			output_enable_n <= 1'b1;
		end else if (en) begin
			unique case (state_q)
				S_IDLE: if (cmd_wr && !((avs_writedata[3:0] == flash_host_pkg::OP_SECTADD) && !win_open)) begin
					op_q   <= avs_writedata[3:0];
					step_q <= 3'h0;
					state_q <= S_SETUP;
				end
				S_SETUP: begin
					chip_enable_n <= 1'b0;
					if (op_len(op_q) == 3'h0) begin
						flash_addr      <= addr_q;
						output_enable_n <= 1'b0;
						cnt_q           <= 8'(flash_host_pkg::ACC_CYC);
						state_q         <= S_RDWAIT;
					end else begin
						{flash_addr, flash_dq_out} <= step_word(op_q, step_q, addr_q, wdata_q);
						flash_dq_oe     <= 1'b1;
						output_enable_n <= 1'b1;
						cnt_q           <= 8'(flash_host_pkg::WP_CYC);
						state_q         <= S_STROBE;
					end
				end
				S_STROBE: begin
					write_enable_n <= 1'b0;
					if (cnt_q == 8'h00) begin
						write_enable_n <= 1'b1;
						state_q        <= S_HOLD;
					end else
						cnt_q <= cnt_q - 8'h01;
				end
				S_HOLD: begin
					chip_enable_n <= 1'b1;
					flash_dq_oe   <= 1'b0;
					if (step_q == op_len(op_q) - 3'h1)
						state_q <= S_IDLE;
					else begin
						step_q  <= step_q + 3'h1;
						state_q <= S_SETUP;
					end
				end
				S_RDWAIT: if (cnt_q == 8'h00) state_q <= S_RDTAKE;
					else cnt_q <= cnt_q - 8'h01;
				S_RDTAKE: begin
					rdata_q         <= dq_s2_q;
					chip_enable_n   <= 1'b1;
					output_enable_n <= 1'b1;
					state_q         <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	AST_NO_OE_DURING_WE: assert property (!write_enable_n |-> output_enable_n && !chip_enable_n)
		else $error("write strobe with output enable or no chip enable");
	AST_WE_WIDTH: assert property ($fell(write_enable_n) && en |-> !write_enable_n [*4])
		else $error("write strobe too short");
	AST_DATA_STABLE: assert property (!write_enable_n |=> $stable(flash_dq_out) && $stable(flash_addr))
		else $error("address or data moved under write strobe");
	AST_DQ_DRIVEN: assert property (!write_enable_n |-> flash_dq_oe)
		else $error("data not driven during write strobe");
	AST_RESET_WORD: assert property ($fell(write_enable_n) && op_q == flash_host_pkg::OP_RESET
		|-> flash_dq_out == flash_host_pkg::CMD_RESET)
		else $error("reset write carries wrong data");
	AST_UNLOCK_FIRST: assert property ($fell(write_enable_n) && step_q == 3'h0 && op_len(op_q) > 3'h2
		|-> flash_addr == flash_host_pkg::UNLOCK1_ADDR && flash_dq_out == flash_host_pkg::UNLOCK1_DATA)
		else $error("sequence does not open with unlock");
	AST_ERASE_LAST: assert property ($fell(write_enable_n) && step_q == 3'h5
		&& op_q == flash_host_pkg::OP_SECTERA |-> flash_dq_out == flash_host_pkg::CMD_SECTERA && ~|flash_addr[15:0])
		else $error("sector erase final write wrong");
	AST_CHIP_LAST: assert property ($fell(write_enable_n) && step_q == 3'h5
		&& op_q == flash_host_pkg::OP_CHIPERA |-> flash_dq_out == flash_host_pkg::CMD_CHIPERA)
		else $error("chip erase final write wrong");
	AST_REFUSE_LATE_ADD: assert property (cmd_wr && avs_writedata[3:0] == flash_host_pkg::OP_SECTADD
		&& !win_open |=> refused_q && !busy)
		else $error("late sector addition not refused");
	AST_AUTOSEL_THREE: assert property ($fell(write_enable_n) && op_q == flash_host_pkg::OP_AUTOSEL
		|-> step_q != 3'h3 && (step_q != 3'h2 || flash_dq_out == flash_host_pkg::CMD_AUTOSEL))
		else $error("autoselect length wrong");

	COV_PROGRAM: cover property ($fell(write_enable_n) && op_q == flash_host_pkg::OP_PROGRAM && step_q == 3'h3);
	COV_SECT_ADD: cover property ($fell(write_enable_n) && op_q == flash_host_pkg::OP_SECTADD);
	COV_REFUSED: cover property ($rose(refused_q));
	COV_READ: cover property (state_q == S_RDTAKE);
endmodule
`default_nettype wire

//--- tb/flash_dev_model.sv
// behavioural byte-wide flash that answers the host controller pins
// assumes strobes, address and write data come straight from the controller
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
	parameter logic [7:0] MAKER_ID = 8'hc5, // arbitrary value
	parameter logic [7:0] PART_ID  = 8'h3c, // arbitrary value
	parameter logic [7:0] CONT_ID  = 8'h9e  // arbitrary value
) (
	input  wire logic [18:0] addr,
	input  wire logic [7:0]  dq_w,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	output logic      [7:0]  dq_r
);
	logic [7:0]  mem [256];
	logic [18:0] log_a [256];
	logic [7:0]  log_d [256];
	logic [18:0] la = 19'h0;
	logic [7:0]  last_q = 8'h00;
	logic [7:0]  rd_v;
	logic        autosel = 1'b0;
	int          n_wr = 0;
	int          bad = 0;
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5a;
	end
	always @(negedge we_n or negedge ce_n)
		if (!we_n && !ce_n) la = addr;
	// data is taken on whichever strobe rises first
	always @(posedge we_n or posedge ce_n)
		if (we_n != ce_n) begin
			if (!oe_n) bad++;
			log_a[n_wr] = la;
			log_d[n_wr] = dq_w;
			// program data may equal the reset word, so the sequence is matched first
			if (n_wr >= 3 && log_d[n_wr-3] == 8'haa && log_d[n_wr-2] == 8'h55 && log_d[n_wr-1] == 8'ha0)
				mem[la[7:0]] = mem[la[7:0]] & dq_w;
			else if (dq_w == 8'hf0) autosel = 1'b0;
			else if (n_wr >= 2 && log_d[n_wr-2] == 8'haa && log_d[n_wr-1] == 8'h55 && dq_w == 8'h90)
				autosel = 1'b1;
			n_wr++;
		end
	// the read value does not depend on the strobes, so capturing it on release has no race
	always @(posedge oe_n)
		last_q = rd_v;
	// a released bus shows the inverse of the last byte, never a stale copy
	always @* begin
		if (autosel)
			rd_v = (addr[7:0] == 8'h00) ? MAKER_ID : (addr[7:0] == 8'h01) ? PART_ID :
				(addr[7:0] == 8'h03) ? CONT_ID : 8'h00;
		else
			rd_v = mem[addr[7:0]];
		dq_r = (!ce_n && !oe_n) ? rd_v : ~last_q;
	end
endmodule
`default_nettype wire

//--- tb/flash_host_tb_top.sv
// self-checking bench of the flash host controller
// assumes the behavioural flash model beside it and the register map of the package
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("Error %0t got %h exp %h", $time, a, b); end end
module flash_host_tb_top;
	localparam int WIN = 40;
	localparam logic [26:0] U1 = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA};
	localparam logic [26:0] U2 = {flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::UNLOCK2_DATA};
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [18:0] flash_addr;
	logic [7:0]  flash_dq_out;
	logic        flash_dq_oe;
	logic [7:0]  dq_r;
	logic        chip_enable_n;
	logic        write_enable_n;
	logic        output_enable_n;
	logic [31:0] s;
	int          fails = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          b;
	initial begin
		forever #5 mclk = ~mclk;
	end
	flash_host #(.WIN_CYCLES(WIN)) flash_host_inst (.mclk(mclk), .rstn(rstn), .en(1'b1),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_addr(flash_addr),
		.flash_dq_in(flash_dq_oe ? flash_dq_out : dq_r), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
		.chip_enable_n(chip_enable_n), .write_enable_n(write_enable_n), .output_enable_n(output_enable_n));
	flash_dev_model flash_dev_model_inst (.addr(flash_addr), .dq_w(flash_dq_out), .ce_n(chip_enable_n),
		.we_n(write_enable_n), .oe_n(output_enable_n), .dq_r(dq_r));
	task automatic report_and_stop();
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	task automatic avs_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask
	task automatic avs_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
	// issue one operation and poll until the controller is idle again
	task automatic op(input logic [3:0] c, input logic [18:0] a, input logic [7:0] d);
		avs_wr(flash_host_pkg::REG_ADDR, {13'h0, a});
		avs_wr(flash_host_pkg::REG_WDATA, {24'h0, d});
		avs_wr(flash_host_pkg::REG_CMD, {28'h0, c});
		s = 32'h1;
		while (s[flash_host_pkg::ST_BUSY] !== 1'b0)
			avs_rd(flash_host_pkg::REG_STATUS, s);
	endtask
	task automatic rd_chk(input logic [18:0] a, input logic [7:0] e);
		op(flash_host_pkg::OP_READ, a, 8'h00);
		avs_rd(flash_host_pkg::REG_STATUS, s);
		`CHK(s[15:8], e)
	endtask
	task automatic chk_log(input int n, input logic [26:0] e [6]);
		`CHK(flash_dev_model_inst.n_wr, b + n)
		for (int i = 0; i < n; i++)
			`CHK({flash_dev_model_inst.log_a[b+i], flash_dev_model_inst.log_d[b+i]}, e[i])
	endtask
	task automatic t_autosel();
		b = flash_dev_model_inst.n_wr;
		op(flash_host_pkg::OP_AUTOSEL, 19'h0, 8'h00);
		chk_log(3, '{U1, U2, {19'h00555, 8'h90}, 27'h0, 27'h0, 27'h0});
		rd_chk(19'h70000, 8'hc5);
		rd_chk(19'h30001, 8'h3c);
		rd_chk(19'h50002, 8'h00);
		rd_chk(19'h00003, 8'h9e);
		b = flash_dev_model_inst.n_wr;
		op(flash_host_pkg::OP_RESET, 19'h4abcd, 8'h00);
		`CHK(flash_dev_model_inst.log_d[b], 8'hf0)
		rd_chk(19'h00000, 8'h5a);
	endtask
	task automatic t_program();
		b = flash_dev_model_inst.n_wr;
		op(flash_host_pkg::OP_PROGRAM, 19'h12345, 8'h0f);
		chk_log(4, '{U1, U2, {19'h00555, 8'ha0}, {19'h12345, 8'h0f}, 27'h0, 27'h0});
		rd_chk(19'h12345, 8'h0f);
		op(flash_host_pkg::OP_PROGRAM, 19'h12345, 8'hf0);
		rd_chk(19'h12345, 8'h00);
	endtask
	task automatic t_erase();
		b = flash_dev_model_inst.n_wr;
		op(flash_host_pkg::OP_CHIPERA, 19'h0, 8'h00);
		chk_log(6, '{U1, U2, {19'h00555, 8'h80}, U1, U2, {19'h00555, 8'h10}});
		b = flash_dev_model_inst.n_wr;
		op(flash_host_pkg::OP_SECTERA, 19'h5abcd, 8'h00);
		chk_log(6, '{U1, U2, {19'h00555, 8'h80}, U1, U2, {19'h50000, 8'h30}});
		avs_rd(flash_host_pkg::REG_STATUS, s);
		`CHK(s[flash_host_pkg::ST_WINOPEN], 1'b1)
		b = flash_dev_model_inst.n_wr;
		op(flash_host_pkg::OP_SECTADD, 19'h3ffff, 8'h00);
		chk_log(1, '{{19'h30000, 8'h30}, 27'h0, 27'h0, 27'h0, 27'h0, 27'h0});
		repeat (WIN + 20) @(posedge mclk);
		avs_rd(flash_host_pkg::REG_STATUS, s);
		`CHK(s[flash_host_pkg::ST_WINOPEN], 1'b0)
		b = flash_dev_model_inst.n_wr;
		op(flash_host_pkg::OP_SUSPEND, 19'h0, 8'h00);
		op(flash_host_pkg::OP_RESUME, 19'h0, 8'h00);
		chk_log(2, '{{19'h0, 8'hb0}, {19'h0, 8'h30}, 27'h0, 27'h0, 27'h0, 27'h0});
		op(flash_host_pkg::OP_SECTADD, 19'h20000, 8'h00);
		avs_rd(flash_host_pkg::REG_STATUS, s);
		`CHK(s[flash_host_pkg::ST_REFUSED], 1'b1)
		`CHK(flash_dev_model_inst.n_wr, b + 2)
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		@(negedge mclk);
		`CHK({chip_enable_n, write_enable_n, output_enable_n, flash_dq_oe}, 4'he)
		rd_chk(19'h00012, 8'h48);
		t_autosel();
		t_program();
		t_erase();
		avs_rd(4'h2, s);
		`CHK(s, 32'h0)
		`CHK(flash_dev_model_inst.bad, 0)
		report_and_stop();
	end
endmodule
`default_nettype wire
